// ===== verilog/hpp_pkg.sv
// package for the host parallel port: register map, select codes, states
// assumes a single 25 MHz cpu clock shared by every user of these constants
package hpp_pkg;
    localparam int HPP_DATA_W = 32;
    localparam int HPP_HALF_W = 16;
    localparam logic [31:0] HPP_CTRL_ADDR = 32'h0188_0000;
    localparam logic [31:0] HPP_WADDR_ADDR = 32'h0188_0004;
    localparam logic [31:0] HPP_RADDR_ADDR = 32'h0188_0008;
    localparam logic [31:0] HPP_TRCTL_ADDR = 32'h018a_0000;
    localparam logic [31:0] HPP_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] HPP_ADDR_RST = 32'h0000_0000;
    localparam logic [31:0] HPP_TRCTL_RST = 32'h0000_0000;
    localparam logic [31:0] HPP_ADDR_STEP = 32'h0000_0004;
    // register select encoding
    localparam logic [1:0] HPP_SEL_CTRL = 2'h0;
    localparam logic [1:0] HPP_SEL_ADDR = 2'h1;
    localparam logic [1:0] HPP_SEL_DATA_INC = 2'h2;
    localparam logic [1:0] HPP_SEL_DATA = 2'h3;
    // pin uses
    localparam logic [1:0] HPP_PIN_PCI = 2'h0;
    localparam logic [1:0] HPP_PIN_WIDE = 2'h1;
    localparam logic [1:0] HPP_PIN_NARROW = 2'h2;

    typedef enum logic [2:0] {
        HPP_IDLE = 3'h0,
        HPP_DECODE = 3'h1,
        HPP_FETCH = 3'h3,
        HPP_WAIT_RISE = 3'h2,
        HPP_PUSH = 3'h6
    } hpp_state_t;

    // one request toward the dma address hardware
    typedef struct packed {
        logic write;
        logic [31:0] addr;
        logic [31:0] data;
    } hpp_req_t;

    // processor-side register access
    typedef struct packed {
        logic sel;
        logic write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } hpp_cpu_req_t;
endpackage

// ===== verilog/hpp_host_port.sv
// host parallel port: host pins, processor register port, dma request path
// assumes host pins are synchronous to sys_clk_i and the dma side answers reads
// with rd_valid_i some cycles after a taken read request
//
// Behaviour
// - host reaches memory through dma address hardware
// - strobe low when selected and strobes differ
// - data read fetches at strobe fall, ready waits
// - write buffer full holds ready high on wide-mode data writes
// - narrow mode: two halves, second from word
// - data bus driven only during read strobe
// - host address write updates both copies
// - data host only; transfer control cpu only; others both sides
// - pins serve pci, wide or narrow+mac
`timescale 1ns/10ps
module hpp_host_port #(
    parameter int BUF_DEPTH = 2
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic [1:0] pin_use_i,
    input wire logic chip_select_n_i,
    input wire logic data_strobe_a_i,
    input wire logic data_strobe_b_i,
    input wire logic read_write_select_i,
    input wire logic [1:0] register_select_i,
    input wire logic half_word_select_i,
    input wire logic address_strobe_n_i,
    input wire logic [31:0] host_data_bus_i,
    output logic [31:0] host_data_bus_o,
    output logic host_data_bus_oe_n_o,
    output logic ready_n_o,
    input wire hpp_pkg::hpp_cpu_req_t cpu_req_i,
    output logic [31:0] cpu_rdata_o,
    output hpp_pkg::hpp_req_t dma_req_o,
    output logic dma_req_valid_o,
    input wire logic dma_req_ready_i,
    input wire logic [31:0] dma_rd_data_i,
    input wire logic dma_rd_valid_i,
    output logic port_enable_o,
    output logic narrow_mode_o,
    output logic mac_pins_o
);
    import hpp_pkg::*;

    initial begin
        if (BUF_DEPTH != 2) begin
            $error("buffer depth must be 2");
        end
    end

    hpp_state_t state_reg, state_next;
    logic [31:0] ctrl_reg, waddr_reg, raddr_reg, trctl_reg, data_reg;
    logic [31:0] rdout_reg, half_reg;
    logic [1:0] sel_reg;
    logic rw_reg, hw_reg, strobe_d_reg, first_half_reg;
    logic [1:0] as_sel_reg;
    logic as_rw_reg, as_hw_reg, as_d_reg, as_pend_reg, fetch_out_reg;
    // host data caught while the strobe is low; the host may change it as it releases
    logic [31:0] hd_hold_reg;

    // pin use decides whether the port is alive and how wide it is
    assign port_enable_o = (pin_use_i == HPP_PIN_WIDE) || (pin_use_i == HPP_PIN_NARROW);
    assign narrow_mode_o = (pin_use_i == HPP_PIN_NARROW);
    assign mac_pins_o = narrow_mode_o;

    wire strobe_n = ~(~(data_strobe_a_i ^ data_strobe_b_i)) & ~chip_select_n_i ? 1'b0 : 1'b1;
    wire strobe_act = ~strobe_n & port_enable_o;
    wire strobe_fall = strobe_act & ~strobe_d_reg;
    wire strobe_rise = ~strobe_act & strobe_d_reg;

    // latched selects from the address strobe win when it was pulsed
    wire as_fall = ~address_strobe_n_i & as_d_reg;
    wire [1:0] sel_now = as_pend_reg ? as_sel_reg : register_select_i;
    wire rw_now = as_pend_reg ? as_rw_reg : read_write_select_i;
    wire hw_now = as_pend_reg ? as_hw_reg : half_word_select_i;

    wire is_data = (sel_reg == HPP_SEL_DATA) || (sel_reg == HPP_SEL_DATA_INC);
    wire is_inc = (sel_reg == HPP_SEL_DATA_INC);
    // narrow mode: half_word_select low means first half
    wire second_half = narrow_mode_o & hw_reg;

    // two-entry write buffer toward the dma side
    hpp_req_t buf_mem [BUF_DEPTH];
    logic wr_ptr_reg, rd_ptr_reg;
    logic [1:0] count_reg;
    wire buf_full = (count_reg == 2'(BUF_DEPTH));
    wire buf_empty = (count_reg == 2'h0);
    wire push_wr = (state_reg == HPP_PUSH) & ~buf_full;
    wire fetch_go = (state_reg == HPP_FETCH) & buf_empty & ~fetch_out_reg;
    wire pop = dma_req_ready_i & dma_req_valid_o;
    hpp_req_t push_req;
    hpp_req_t fetch_req;
    hpp_req_t narrow_req;

    always_comb begin
        push_req.write = 1'b1;
        push_req.addr = waddr_reg;
        push_req.data = narrow_mode_o ? {host_data_bus_i[15:0], half_reg[15:0]} : host_data_bus_i;
        fetch_req.write = 1'b0;
        fetch_req.addr = raddr_reg;
        fetch_req.data = 32'h0000_0000;
        narrow_req.write = 1'b1;
        narrow_req.addr = waddr_reg;
        narrow_req.data = {hd_hold_reg[15:0], half_reg[15:0]};
    end

    // reads are issued only with the write buffer drained, keeping order
    assign dma_req_valid_o = ~buf_empty | fetch_go;
    assign dma_req_o = buf_empty ? fetch_req : buf_mem[rd_ptr_reg];

    // sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            HPP_IDLE: begin
                if (strobe_fall) begin
                    state_next = HPP_DECODE;
                end
            end
            HPP_DECODE: begin
                if (!is_data || second_half) begin
                    state_next = HPP_WAIT_RISE;
                end else if (rw_reg) begin
                    state_next = HPP_FETCH;
                end else if (narrow_mode_o) begin
                    state_next = HPP_WAIT_RISE;
                end else begin
                    state_next = HPP_PUSH;
                end
            end
            HPP_FETCH: begin
                if (dma_rd_valid_i && fetch_out_reg) begin
                    state_next = HPP_WAIT_RISE;
                end
            end
            HPP_PUSH: begin
                if (!buf_full) begin
                    state_next = HPP_WAIT_RISE;
                end
            end
            HPP_WAIT_RISE: begin
                if (!strobe_act) begin
                    state_next = HPP_IDLE;
                end
            end
            default: state_next = HPP_IDLE;
        endcase
    end

    // ready low in idle and after the access is served
    assign ready_n_o = ~((state_reg == HPP_IDLE) || (state_reg == HPP_WAIT_RISE));

    assign host_data_bus_oe_n_o = ~(strobe_act & rw_reg & (state_reg != HPP_IDLE));
    assign host_data_bus_o = rdout_reg;

    // host register writes land as the strobe rises, from the data held while it was low
    wire host_wr_rise = strobe_rise & ~rw_reg & (state_reg == HPP_WAIT_RISE);
    wire [31:0] host_word = narrow_mode_o ?
        {hd_hold_reg[15:0], half_reg[15:0]} : hd_hold_reg;
    wire host_word_done = ~narrow_mode_o | hw_reg;
    wire cpu_wr = cpu_req_i.sel & cpu_req_i.write;
    wire data_step = is_data & is_inc & (state_reg == HPP_WAIT_RISE) & strobe_rise
        & (~narrow_mode_o | hw_reg);

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            state_reg <= HPP_IDLE;
            strobe_d_reg <= 1'b0;
            sel_reg <= HPP_SEL_CTRL;
            rw_reg <= 1'b0;
            hw_reg <= 1'b0;
            as_d_reg <= 1'b1;
            as_pend_reg <= 1'b0;
            as_sel_reg <= HPP_SEL_CTRL;
            as_rw_reg <= 1'b0;
            as_hw_reg <= 1'b0;
            fetch_out_reg <= 1'b0;
            hd_hold_reg <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
            if (strobe_act) begin
                hd_hold_reg <= host_data_bus_i;
            end
            strobe_d_reg <= strobe_act;
            as_d_reg <= address_strobe_n_i;
            if (as_fall) begin
                as_pend_reg <= 1'b1;
                as_sel_reg <= register_select_i;
                as_rw_reg <= read_write_select_i;
                as_hw_reg <= half_word_select_i;
            end else if (strobe_rise) begin
                as_pend_reg <= 1'b0;
            end
            if (strobe_fall) begin
                sel_reg <= sel_now;
                rw_reg <= rw_now;
                hw_reg <= hw_now;
            end
            if (fetch_go && dma_req_ready_i) begin
                fetch_out_reg <= 1'b1;
            end else if (dma_rd_valid_i) begin
                fetch_out_reg <= 1'b0;
            end
        end
    end

    // registers; a host address write fills both copies
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            ctrl_reg <= HPP_CTRL_RST;
            waddr_reg <= HPP_ADDR_RST;
            raddr_reg <= HPP_ADDR_RST;
            trctl_reg <= HPP_TRCTL_RST;
            data_reg <= 32'h0000_0000;
            half_reg <= 32'h0000_0000;
        end else begin
            if (host_wr_rise && narrow_mode_o && !hw_reg) begin
                half_reg <= {16'h0000, hd_hold_reg[15:0]};
            end
            if (host_wr_rise && host_word_done && sel_reg == HPP_SEL_ADDR) begin
                waddr_reg <= host_word;
                raddr_reg <= host_word;
            end else begin
                if (cpu_wr && cpu_req_i.addr == HPP_WADDR_ADDR) begin
                    waddr_reg <= cpu_req_i.wdata;
                end else if (push_wr && is_inc) begin
                    waddr_reg <= waddr_reg + HPP_ADDR_STEP;
                end
                if (cpu_wr && cpu_req_i.addr == HPP_RADDR_ADDR) begin
                    raddr_reg <= cpu_req_i.wdata;
                end else if (data_step && rw_reg) begin
                    raddr_reg <= raddr_reg + HPP_ADDR_STEP;
                end
            end
            if (host_wr_rise && host_word_done && sel_reg == HPP_SEL_CTRL) begin
                ctrl_reg <= host_word;
            end else if (cpu_wr && cpu_req_i.addr == HPP_CTRL_ADDR) begin
                ctrl_reg <= cpu_req_i.wdata;
            end
            if (cpu_wr && cpu_req_i.addr == HPP_TRCTL_ADDR) begin
                trctl_reg <= cpu_req_i.wdata;
            end
            if (dma_rd_valid_i && fetch_out_reg) begin
                data_reg <= dma_rd_data_i;
            end
        end
    end

    // narrow-mode writes to data are pushed after the second half arrives
    logic push_narrow_reg;
    wire push_any = push_wr | (push_narrow_reg & ~buf_full);
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
            push_narrow_reg <= 1'b0;
        end else begin
            if (host_wr_rise && is_data && narrow_mode_o && hw_reg) begin
                push_narrow_reg <= 1'b1;
            end else if (push_narrow_reg && !buf_full) begin
                push_narrow_reg <= 1'b0;
            end
            if (push_any) begin
                // a narrow push delayed by a full buffer relies on no new strobe meanwhile
                buf_mem[wr_ptr_reg] <= push_wr ? push_req : narrow_req;
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop && !buf_empty) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            count_reg <= count_reg + 2'(push_any) - 2'(pop & ~buf_empty);
        end
    end

    // read data mux; the second half comes from the word already held
    wire [31:0] sel_word = (sel_reg == HPP_SEL_CTRL) ? ctrl_reg :
        (sel_reg == HPP_SEL_ADDR) ? raddr_reg :
        ((dma_rd_valid_i && fetch_out_reg) ? dma_rd_data_i : data_reg);
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            rdout_reg <= 32'h0000_0000;
        end else if (state_reg == HPP_DECODE || state_reg == HPP_FETCH) begin
            rdout_reg <= (narrow_mode_o && hw_reg) ? {16'h0000, sel_word[31:16]} :
                (narrow_mode_o ? {16'h0000, sel_word[15:0]} : sel_word);
        end
    end

    wire [31:0] cpu_rd = (cpu_req_i.addr == HPP_CTRL_ADDR) ? ctrl_reg :
        (cpu_req_i.addr == HPP_WADDR_ADDR) ? waddr_reg :
        (cpu_req_i.addr == HPP_RADDR_ADDR) ? raddr_reg :
        (cpu_req_i.addr == HPP_TRCTL_ADDR) ? trctl_reg : 32'h0000_0000;
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            cpu_rdata_o <= 32'h0000_0000;
        end else if (cpu_req_i.sel) begin
            cpu_rdata_o <= cpu_rd;
        end
    end

    AST_IDLE_READY: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        state_reg == HPP_IDLE |-> !ready_n_o) else $error("ready high in idle");
    AST_READ_WAIT: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        state_reg == HPP_FETCH |-> ready_n_o) else $error("ready low during fetch");
    AST_FULL_STALL: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        state_reg == HPP_PUSH && buf_full |-> ready_n_o) else $error("ready low on full");
    AST_BUS_IDLE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !strobe_act |-> host_data_bus_oe_n_o) else $error("bus driven without strobe");
    AST_ADDR_BOTH: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        host_wr_rise && host_word_done && sel_reg == HPP_SEL_ADDR
        |=> waddr_reg == raddr_reg) else $error("address copies differ");
    AST_FETCH_ONCE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        state_reg == HPP_DECODE && second_half |=> state_reg != HPP_FETCH)
        else $error("second half refetched");
    AST_STROBE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (chip_select_n_i || data_strobe_a_i == data_strobe_b_i) |-> !strobe_act)
        else $error("strobe active wrongly");
    AST_BUF_BOUND: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        count_reg <= 2'(BUF_DEPTH)) else $error("buffer overflow");
    AST_DATA_LOAD: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        dma_rd_valid_i && fetch_out_reg |=> data_reg == $past(dma_rd_data_i))
        else $error("fetched word not held");
    AST_ENABLE: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        pin_use_i == HPP_PIN_PCI |-> !strobe_act) else $error("port live in pci use");

    COV_READ: cover property (@(posedge sys_clk_i) disable iff (reset_i)
        state_reg == HPP_FETCH ##[1:20] state_reg == HPP_WAIT_RISE);
    COV_FULL: cover property (@(posedge sys_clk_i) disable iff (reset_i) buf_full);
    COV_NARROW: cover property (@(posedge sys_clk_i) disable iff (reset_i)
        narrow_mode_o && push_narrow_reg);
    COV_AS: cover property (@(posedge sys_clk_i) disable iff (reset_i) as_fall);
endmodule

// ===== testbench/hpp_dma_model.sv
// dma-side partner: takes requests by valid/ready, answers reads with addr xor key
// assumes one outstanding read at a time, which the port keeps by waiting in fetch for each answer
`timescale 1ns/10ps
module hpp_dma_model (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic stall_i,
    input wire logic slow_i,
    input wire hpp_pkg::hpp_req_t req_i,
    input wire logic valid_i,
    output logic ready_o,
    output logic [31:0] rd_data_o,
    output logic rd_valid_o
);
    import hpp_pkg::*;
    localparam logic [31:0] MEM_KEY = 32'h5a5a_a5a5;
    int cnt;
    logic [31:0] addr_hold;
    assign ready_o = !stall_i;
    always @(posedge clk_i) begin
        // data lines toggle outside the answer so a stale word is never mistaken
        rd_data_o <= ~rd_data_o;
        rd_valid_o <= 1'b0;
        if (reset_i) begin
            cnt <= 0;
            rd_data_o <= 32'h0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end else if (cnt == 1) begin
            cnt <= 0;
            rd_valid_o <= 1'b1;
            rd_data_o <= addr_hold ^ MEM_KEY;
        end else if (valid_i && ready_o && !req_i.write) begin
            addr_hold <= req_i.addr;
            cnt <= slow_i ? 6 : 1;
        end
    end
endmodule

// ===== testbench/hpp_host_port_tb_top.sv
// testbench for the host parallel port: host pin driver, cpu port, dma checks
// assumes hpp_dma_model as the dma side; expected dma requests go through a queue
`timescale 1ns/10ps
module hpp_host_port_tb_top;
    import hpp_pkg::*;
    localparam logic [31:0] MEM_KEY = 32'h5a5a_a5a5;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [1:0] pin_use = HPP_PIN_WIDE;
    logic cs_n = 1'b1, sa = 1'b0, sb = 1'b0, rw = 1'b0, hws = 1'b0, as_n = 1'b1;
    logic [1:0] rsel = 2'h0;
    logic [31:0] hd_i = 32'h0, hd_o, cpu_rd, rd_data, r, a, d0, d1;
    logic oe_n, ready_n, req_valid, req_ready, rd_valid, port_en, narrow, mac;
    logic stall = 1'b0, slow = 1'b0, use_as = 1'b0;
    hpp_cpu_req_t cpu_req = '0;
    hpp_req_t dma_req, e;
    hpp_req_t exp_q[$];
    int n_mismatch = 0, comparisons = 0, n_req = 0, n = 0, seed = 32'hb351;
    always #20 sys_clk_i = ~sys_clk_i;
    hpp_host_port hpp_host_port_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .pin_use_i(pin_use), .chip_select_n_i(cs_n), .data_strobe_a_i(sa),
        .data_strobe_b_i(sb), .read_write_select_i(rw), .register_select_i(rsel),
        .half_word_select_i(hws), .address_strobe_n_i(as_n), .host_data_bus_i(hd_i),
        .host_data_bus_o(hd_o), .host_data_bus_oe_n_o(oe_n), .ready_n_o(ready_n),
        .cpu_req_i(cpu_req), .cpu_rdata_o(cpu_rd), .dma_req_o(dma_req),
        .dma_req_valid_o(req_valid), .dma_req_ready_i(req_ready),
        .dma_rd_data_i(rd_data), .dma_rd_valid_i(rd_valid), .port_enable_o(port_en),
        .narrow_mode_o(narrow), .mac_pins_o(mac));
    hpp_dma_model hpp_dma_model_i (.clk_i(sys_clk_i), .reset_i(reset_i), .stall_i(stall),
        .slow_i(slow), .req_i(dma_req), .valid_i(req_valid), .ready_o(req_ready),
        .rd_data_o(rd_data), .rd_valid_o(rd_valid));
    task automatic chk(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic done(input string s);
        $display("test %s finished, mismatches so far %0d", s, n_mismatch);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cpu(input logic w, input logic [31:0] ad, wd, output logic [31:0] rd);
        @(negedge sys_clk_i);
        cpu_req = {1'b1, w, ad, wd};
        @(negedge sys_clk_i);
        cpu_req.sel = 1'b0;
        rd = cpu_rd;
    endtask
    task automatic host(input logic rd, input logic [1:0] sel, input logic hw,
                        input logic [31:0] wd, output logic [31:0] rv);
        int k;
        @(negedge sys_clk_i);
        rw = rd;
        rsel = sel;
        hws = hw;
        hd_i = wd;
        as_n = ~use_as;
        @(negedge sys_clk_i);
        cs_n = 1'b0;
        {sa, sb} = use_as ? 2'b01 : 2'b10;
        k = 0;
        do begin
            @(negedge sys_clk_i);
            k++;
        end while (ready_n !== 1'b0 && k < 300);
        chk(k < 300, "ready never came");
        rv = hd_o;
        if (rd) chk(oe_n === 1'b0, "bus not driven in read");
        // strobe held across the edge that samples ready low
        @(negedge sys_clk_i);
        cs_n = 1'b1;
        {sa, sb} = 2'b00;
        as_n = 1'b1;
        hd_i = ~wd;
        repeat (2) @(negedge sys_clk_i);
        chk(oe_n === 1'b1, "bus still driven after strobe");
    endtask
    always @(posedge sys_clk_i) begin
        if (!reset_i && req_valid === 1'b1 && req_ready === 1'b1) begin
            n_req++;
            if (exp_q.size() == 0) begin
                chk(1'b0, "unexpected dma request");
            end else begin
                e = exp_q.pop_front();
                chk(dma_req.write === e.write && dma_req.addr === e.addr &&
                    (!e.write || dma_req.data === e.data), "dma request");
            end
        end
    end
    initial begin
        #(40 * 20000);
        n_mismatch++;
        $display("[FAIL] %0t run did not finish in time", $time);
        give_verdict();
    end
    initial begin
        repeat (3) @(negedge sys_clk_i);
        chk(ready_n === 1'b0 && oe_n === 1'b1 && req_valid === 1'b0, "reset");
        reset_i = 1'b0;
        cpu(1'b0, HPP_CTRL_ADDR, 32'h0, r);
        chk(r === HPP_CTRL_RST, "control reset");
        cpu(1'b0, HPP_WADDR_ADDR, 32'h0, r);
        chk(r === HPP_ADDR_RST, "write address reset");
        cpu(1'b0, HPP_TRCTL_ADDR, 32'h0, r);
        chk(r === HPP_TRCTL_RST, "transfer control reset");
        for (int u = 0; u < 3; u++) begin
            pin_use = u[1:0];
            #1;
            chk(port_en === (u != 0) && narrow === (u == 2) && mac === (u == 2), "pins");
        end
        pin_use = HPP_PIN_WIDE;
        done("reset");
        a = $random(seed);
        a[1:0] = 2'h0;
        host(1'b0, HPP_SEL_ADDR, 1'b0, a, r);
        cpu(1'b0, HPP_WADDR_ADDR, 32'h0, r);
        chk(r === a, "host address to write copy");
        cpu(1'b0, HPP_RADDR_ADDR, 32'h0, r);
        chk(r === a, "host address to read copy");
        d0 = $random(seed);
        host(1'b0, HPP_SEL_CTRL, 1'b0, d0, r);
        host(1'b1, HPP_SEL_CTRL, 1'b0, 32'h0, r);
        chk(r === d0, "host control readback");
        cpu(1'b0, HPP_CTRL_ADDR, 32'h0, r);
        chk(r === d0, "cpu sees host control");
        cpu(1'b1, HPP_TRCTL_ADDR, ~d0, r);
        cpu(1'b0, 32'h0188_000c, 32'h0, r);
        chk(r === 32'h0, "unmapped reads zero");
        cpu(1'b0, HPP_TRCTL_ADDR, 32'h0, r);
        chk(r === ~d0, "transfer control readback");
        done("registers");
        // far side stalls so the two-entry buffer fills and the third write waits
        stall = 1'b1;
        for (int i = 0; i < 3; i++) begin
            d0 = $random(seed);
            exp_q.push_back({1'b1, a + 32'(4 * i), d0});
            fork
                host(1'b0, HPP_SEL_DATA_INC, 1'b0, d0, r);
                if (i == 2) begin
                    repeat (20) @(negedge sys_clk_i);
                    chk(ready_n === 1'b1, "ready while buffer full");
                    stall = 1'b0;
                end
            join
        end
        repeat (10) @(negedge sys_clk_i);
        chk(exp_q.size() == 0, "buffered writes drained");
        done("write buffer");
        slow = 1'b1;
        use_as = 1'b1;
        exp_q.push_back({1'b0, a, 32'h0});
        host(1'b1, HPP_SEL_DATA_INC, 1'b0, 32'h0, r);
        chk(r === (a ^ MEM_KEY), "slow read data");
        slow = 1'b0;
        exp_q.push_back({1'b0, a + 32'h4, 32'h0});
        host(1'b1, HPP_SEL_DATA, 1'b0, 32'h0, r);
        chk(r === ((a + 32'h4) ^ MEM_KEY), "read after increment");
        cpu(1'b1, HPP_RADDR_ADDR, a + 32'h40, r);
        cpu(1'b0, HPP_WADDR_ADDR, 32'h0, r);
        chk(r === a + 32'hc, "write copy independent");
        exp_q.push_back({1'b0, a + 32'h40, 32'h0});
        host(1'b1, HPP_SEL_DATA, 1'b0, 32'h0, r);
        chk(r === ((a + 32'h40) ^ MEM_KEY), "read from cpu address");
        use_as = 1'b0;
        done("reads");
        pin_use = HPP_PIN_NARROW;
        d0 = $random(seed);
        d1 = $random(seed);
        cpu(1'b1, HPP_WADDR_ADDR, a, r);
        cpu(1'b1, HPP_RADDR_ADDR, a, r);
        exp_q.push_back({1'b1, a, d1[15:0], d0[15:0]});
        host(1'b0, HPP_SEL_DATA, 1'b0, {16'h0, d0[15:0]}, r);
        host(1'b0, HPP_SEL_DATA, 1'b1, {16'h0, d1[15:0]}, r);
        exp_q.push_back({1'b0, a, 32'h0});
        host(1'b1, HPP_SEL_DATA, 1'b0, 32'h0, r);
        chk(r[15:0] === (a[15:0] ^ MEM_KEY[15:0]), "first half");
        n = n_req;
        host(1'b1, HPP_SEL_DATA, 1'b1, 32'h0, r);
        chk(r[15:0] === (a[31:16] ^ MEM_KEY[31:16]), "second half");
        chk(n_req == n, "second half fetched again");
        done("narrow");
        // pci use ignores the pins; equal strobes are no access in wide use
        for (int k = 0; k < 2; k++) begin
            pin_use = k ? HPP_PIN_WIDE : HPP_PIN_PCI;
            @(negedge sys_clk_i);
            rw = 1'b1;
            rsel = HPP_SEL_DATA;
            cs_n = 1'b0;
            {sa, sb} = k ? 2'b11 : 2'b10;
            n = n_req;
            repeat (8) @(negedge sys_clk_i);
            chk(oe_n === 1'b1 && n_req == n, "idle strobe took effect");
            cs_n = 1'b1;
            {sa, sb} = 2'b00;
        end
        repeat (4) @(negedge sys_clk_i);
        chk(exp_q.size() == 0, "dma requests missing");
        done("ignored strobes");
        give_verdict();
    end
endmodule
